/* src/twr_bit_engine.sv */
`timescale 1ns/1ps
module twr_bit_engine
	import twr_pkg::*;
(
	input  wire logic    clk_i,
	input  wire logic    resetn_i,
	input  wire logic    ce_i,
	input  wire logic    op_valid_i,
	input  wire twr_op_e op_i,
	input  wire logic    op_bit_i,
	output logic         op_ready_o,
	output logic         done_o,
	output logic         rx_bit_o,
	input  wire logic    sda_i,
	output logic         scl_oe_o,
	output logic         sda_oe_o
);

	function automatic logic [11:0] phase_len(input twr_op_e op, input logic [1:0] ph);
		logic [11:0] len;
		len = ONE_CYC;
		case (op)
			OP_START: len = (ph == 2'h0) ? T_LOW_CYC : (ph == 2'h1) ? T_SU_STA_CYC :
				(ph == 2'h2) ? T_HD_STA_CYC : ONE_CYC;
			OP_BIT:   len = (ph == 2'h0) ? T_LOW_CYC : (ph == 2'h1) ? T_HIGH_CYC : T_HD_DAT_CYC;
			OP_STOP:  len = (ph == 2'h0) ? T_LOW_CYC : (ph == 2'h1) ? T_SU_STO_CYC : T_BUF_CYC;
			default:  len = ONE_CYC;
		endcase
		return len;
	endfunction

	twr_op_e     op;
	logic        obit;
	logic        busy;
	logic [1:0]  ph;
	logic [11:0] cnt;
	logic        scl_low;
	logic        sda_low;
	logic        sda_meta;
	logic        sda_sync;

	wire         accept   = op_valid_i && !busy;
	wire         ph_end   = busy && (cnt == ONE_CYC);
	wire         is_last  = (op == OP_START) ? (ph == 2'h3) : (ph == 2'h2);
	wire         finish   = ph_end && is_last;
	wire         advance  = accept || (ph_end && !is_last);
	wire twr_op_e nop     = busy ? op : op_i;
	wire         nbit     = busy ? obit : op_bit_i;
	wire [1:0]   nph      = busy ? 2'(ph + 2'h1) : 2'h0;
	wire [11:0]  next_cnt = advance ? phase_len(nop, nph) : 12'(cnt - ONE_CYC);
	// Clock is released only for the high phase; it is never stretched by the target.
	wire         next_scl = (nop == OP_START) ? ((nph == 2'h0) ? scl_low : (nph == 2'h3)) :
		(nop == OP_STOP) ? (nph == 2'h0) : (nph != 2'h1);
	// Data bits move only while the clock is low; start and stop move data with the clock high.
	wire         next_sda = (nop == OP_START) ? (nph >= 2'h2) :
		(nop == OP_STOP) ? (nph != 2'h2) : ((nph == 2'h0) ? !nbit : sda_low);
	wire         sample   = ph_end && (op == OP_BIT) && (ph == 2'h1);

	assign op_ready_o = !busy;
	assign scl_oe_o   = scl_low;
	assign sda_oe_o   = sda_low;

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			{sda_meta, sda_sync} <= 2'h3;
		end
		else if (ce_i)
		begin
			{sda_meta, sda_sync} <= {sda_i, sda_meta};
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			busy    <= 1'h0;
			op      <= OP_START;
			obit    <= 1'h1;
			ph      <= 2'h0;
			cnt     <= ONE_CYC;
			scl_low <= 1'h0;
			sda_low <= 1'h0;
			done_o  <= 1'h0;
		end
		else if (ce_i)
		begin
			done_o <= finish;
			if (finish)
				busy <= 1'h0;
			else if (accept)
			begin
				busy <= 1'h1;
				op   <= op_i;
				obit <= op_bit_i;
			end
			if (busy || accept)
				cnt <= next_cnt;
			if (advance)
			begin
				ph      <= nph;
				scl_low <= next_scl;
				sda_low <= next_sda;
			end
		end
	end

	// Data is sampled at the end of the high phase, after the two-stage synchroniser.
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			rx_bit_o <= 1'h1;
		else if (ce_i && sample)
			rx_bit_o <= sda_sync;
	end

endmodule

/* src/twr_master.sv */
`timescale 1ns/1ps
// Behaviour
// - Data line is open-drain; either side pulls low or releases.
// - Bus idles with both lines high; only this master makes start/stop.
// - Data falling while clock high is a start.
// - A start without prior stop is a repeated start.
// - Data rising while clock high is a stop, releasing the bus.
// - Bytes are eight bits, MSB first, each followed by an acknowledge bit.
// - One bit per clock period; data changes only while clock is low.
// - Address byte holds seven-bit address above a direction bit, one meaning read.
// - Transmitter releases data in the acknowledge slot; receiver pulls it low.
// - A high acknowledge slot is a no-acknowledge; it ends reads.
// - After write address byte, send 16-bit register address as two bytes.
// - Register address goes upper byte first.
// - Write data follows byte by byte, ended by stop or repeated start.
// - Further write bytes go to following register locations.
// - Master acknowledges each read byte while it wants more.
// - Read ends with master no-acknowledge, then stop.
// - Random read: dummy write with address, repeated start, read address byte.
module twr_master
	import twr_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	input  wire logic        ce_i,
	input  wire logic        cmd_valid_i,
	output logic             cmd_ready_o,
	input  wire logic        cmd_read_i,
	input  wire logic        cmd_random_i,
	input  wire logic [6:0]  cmd_dev_addr_i,
	input  wire logic [15:0] cmd_reg_addr_i,
	input  wire logic [7:0]  cmd_len_i,
	input  wire logic [7:0]  wr_data_i,
	input  wire logic        wr_valid_i,
	output logic             wr_ready_o,
	output logic [7:0]       rd_data_o,
	output logic             rd_valid_o,
	output logic             done_o,
	output logic             nack_o,
	output logic             busy_o,
	output logic             scl_o,
	output logic             scl_oe_o,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_o
);

	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_LOAD, ST_BIT, ST_STOP} twr_st_e;
	typedef enum logic [2:0] {SEG_DEVW, SEG_REGH, SEG_REGL, SEG_WDATA, SEG_DEVR,
		SEG_RDATA} twr_seg_e;

	twr_st_e     st;
	twr_seg_e    seg;
	logic        pending;
	logic        is_read;
	logic [6:0]  dev;
	logic [15:0] reg_addr;
	logic [7:0]  left;
	logic [7:0]  shreg;
	logic [3:0]  bitn;

	twr_st_e     next_st;
	twr_seg_e    next_seg;
	logic        next_pending;
	logic        next_is_read;
	logic [6:0]  next_dev;
	logic [15:0] next_reg_addr;
	logic [7:0]  next_left;
	logic [7:0]  next_shreg;
	logic [3:0]  next_bitn;
	logic        next_nack;
	logic        next_done;
	logic        next_rd_valid;
	logic [7:0]  next_rd_data;

	logic        eng_ready;
	logic        eng_done;
	logic        eng_rx;

	wire          rd_seg   = (seg == SEG_RDATA);
	wire          last_rd  = (left <= 8'h01);
	wire          ack_slot = (bitn == ACK_SLOT);
	wire          waiting  = !pending && eng_done;
	wire          cmd_take = cmd_valid_i && (st == ST_IDLE);
	wire twr_op_e eng_op   = (st == ST_START) ? OP_START : (st == ST_STOP) ? OP_STOP : OP_BIT;
	wire          eng_val  = pending && ((st == ST_START) || (st == ST_BIT) || (st == ST_STOP));
	// Write bytes go out MSB first and release data for the target's acknowledge.
	wire          tx_bit   = ack_slot ? 1'h1 : shreg[7];
	// Read bytes are sampled released, then acknowledged low or, on the last, left high.
	wire          rx_ackb  = ack_slot ? last_rd : 1'h1;
	wire          op_bit   = rd_seg ? rx_ackb : tx_bit;
	// The write source has no timeout: while it stalls the clock stays low, which the bus
	// tolerates because only this end drives the clock.
	wire          wr_need  = (st == ST_LOAD) && (seg == SEG_WDATA) && (left != 8'h00);

	assign cmd_ready_o = (st == ST_IDLE);
	assign wr_ready_o  = wr_need;
	assign busy_o      = (st != ST_IDLE);
	// Both lines are open-drain; the low level is the only one ever driven.
	assign scl_o       = 1'h0;
	assign sda_o       = 1'h0;

	twr_bit_engine u_eng
	(
		.clk_i      (clk_i),
		.resetn_i   (resetn_i),
		.ce_i       (ce_i),
		.op_valid_i (eng_val),
		.op_i       (eng_op),
		.op_bit_i   (op_bit),
		.op_ready_o (eng_ready),
		.done_o     (eng_done),
		.rx_bit_o   (eng_rx),
		.sda_i      (sda_i),
		.scl_oe_o   (scl_oe_o),
		.sda_oe_o   (sda_oe_o)
	);

	// Every byte is nine bit operations: eight data bits, then the acknowledge slot.
	// Pending marks an operation that the engine has not yet taken.
	always_comb
	begin
		next_st       = st;
		next_seg      = seg;
		next_pending  = pending && !(eng_val && eng_ready);
		next_is_read  = is_read;
		next_dev      = dev;
		next_reg_addr = reg_addr;
		next_left     = left;
		next_shreg    = shreg;
		next_bitn     = bitn;
		next_nack     = nack_o;
		next_done     = 1'h0;
		next_rd_valid = 1'h0;
		next_rd_data  = rd_data_o;
		case (st)
			ST_IDLE:
			begin
				if (cmd_take)
				begin
					next_is_read  = cmd_read_i;
					next_dev      = cmd_dev_addr_i;
					next_reg_addr = cmd_reg_addr_i;
					next_left     = cmd_len_i;
					next_nack     = 1'h0;
					// A read without address phase goes straight to the read address.
					next_seg      = (cmd_read_i && !cmd_random_i) ? SEG_DEVR : SEG_DEVW;
					next_st       = ST_START;
					next_pending  = 1'h1;
				end
			end
			ST_START:
			begin
				// Bus is claimed from idle, or restarted without a stop.
				if (waiting)
					next_st = ST_LOAD;
			end
			ST_LOAD:
			begin
				next_bitn    = 4'h0;
				next_st      = ST_BIT;
				next_pending = 1'h1;
				case (seg)
					SEG_DEVW:  next_shreg = {dev, DIR_WRITE};
					SEG_REGH:  next_shreg = reg_addr[15:8];
					SEG_REGL:  next_shreg = reg_addr[7:0];
					SEG_DEVR:  next_shreg = {dev, DIR_READ};
					SEG_RDATA: next_shreg = 8'h00;
					SEG_WDATA:
					begin
						next_shreg = wr_data_i;
						if (left == 8'h00)
						begin
							next_st = ST_STOP;
						end
						else if (!wr_valid_i)
						begin
							// Clock is held low while the write source stalls.
							next_st      = ST_LOAD;
							next_pending = 1'h0;
						end
					end
					default:   next_shreg = 8'h00;
				endcase
			end
			ST_BIT:
			begin
				if (waiting && !ack_slot)
				begin
					next_shreg   = {shreg[6:0], eng_rx};
					next_bitn    = 4'(bitn + 4'h1);
					next_pending = 1'h1;
				end
				else if (waiting && rd_seg)
				begin
					next_rd_valid = 1'h1;
					next_rd_data  = shreg;
					next_left     = 8'(left - 8'h01);
					// Master no-acknowledge on the last byte, then stop.
					next_st       = last_rd ? ST_STOP : ST_LOAD;
					next_pending  = last_rd;
				end
				else if (waiting && eng_rx)
				begin
					// No acknowledge: unmatched or refusing target, so give up.
					next_nack    = 1'h1;
					next_st      = ST_STOP;
					next_pending = 1'h1;
				end
				else if (waiting)
				begin
					next_st = ST_LOAD;
					case (seg)
						SEG_DEVW:  next_seg = SEG_REGH;
						SEG_REGH:  next_seg = SEG_REGL;
						// Random read: dummy write, then repeated start.
						SEG_REGL:  next_seg = is_read ? SEG_DEVR : SEG_WDATA;
						SEG_DEVR:  next_seg = SEG_RDATA;
						// Each further byte lands on the next location in the target.
						SEG_WDATA: next_left = 8'(left - 8'h01);
						default:   next_seg = seg;
					endcase
					if ((seg == SEG_REGL) && is_read)
					begin
						next_st      = ST_START;
						next_pending = 1'h1;
					end
				end
			end
			ST_STOP:
			begin
				// Stop returns the bus to idle.
				if (waiting)
				begin
					next_st   = ST_IDLE;
					next_done = 1'h1;
				end
			end
			default:
			begin
				next_st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			st       <= ST_IDLE;
			seg      <= SEG_DEVW;
			pending  <= 1'h0;
			is_read  <= 1'h0;
			dev      <= DEV_ADDR_DEFAULT;
			reg_addr <= 16'h0000;
			left     <= 8'h00;
			shreg    <= 8'h00;
			bitn     <= 4'h0;
		end
		else if (ce_i)
		begin
			st       <= next_st;
			seg      <= next_seg;
			pending  <= next_pending;
			is_read  <= next_is_read;
			dev      <= next_dev;
			reg_addr <= next_reg_addr;
			left     <= next_left;
			shreg    <= next_shreg;
			bitn     <= next_bitn;
		end
	end

	// Status outputs are registered; done and read-valid are one-cycle pulses, while nack holds until the next command.
	// Read data stands until the next byte replaces it.
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			nack_o     <= 1'h0;
			done_o     <= 1'h0;
			rd_valid_o <= 1'h0;
			rd_data_o  <= 8'h00;
		end
		else if (ce_i)
		begin
			nack_o     <= next_nack;
			done_o     <= next_done;
			rd_valid_o <= next_rd_valid;
			rd_data_o  <= next_rd_data;
		end
	end

endmodule

/* src/twr_pkg.sv */
package twr_pkg;

	// System clock rate, in MHz.
	localparam int unsigned CLK_MHZ = 250;

	// Bus timing, fast mode, in ns.
	localparam int unsigned T_LOW_NS    = 1300;
	localparam int unsigned T_HIGH_NS   = 600;
	localparam int unsigned T_SU_STA_NS = 600;
	localparam int unsigned T_HD_STA_NS = 600;
	localparam int unsigned T_SU_STO_NS = 600;
	localparam int unsigned T_BUF_NS    = 1300;
	localparam int unsigned T_HD_DAT_NS = 300;

	// Minimum times round up to whole cycles.
	localparam logic [11:0] T_LOW_CYC    = 12'((T_LOW_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] T_HIGH_CYC   = 12'((T_HIGH_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] T_SU_STA_CYC = 12'((T_SU_STA_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] T_HD_STA_CYC = 12'((T_HD_STA_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] T_SU_STO_CYC = 12'((T_SU_STO_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] T_BUF_CYC    = 12'((T_BUF_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] T_HD_DAT_CYC = 12'((T_HD_DAT_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] ONE_CYC      = 12'h001;

	// Seven-bit target addresses: 0x10 default, 0x18 alternate (address bytes 0x20/0x21, 0x30/0x31).
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h10;
	localparam logic [6:0] DEV_ADDR_ALT     = 7'h18;

	// Direction bit values in the address byte.
	localparam logic DIR_WRITE = 1'h0;
	localparam logic DIR_READ  = 1'h1;

	// Last bit of a byte is the acknowledge slot.
	localparam logic [3:0] ACK_SLOT = 4'h8;

	typedef enum logic [1:0] {OP_START, OP_BIT, OP_STOP} twr_op_e;

endpackage

/* verification/test_two_wire_register_slave.sv */
`timescale 1ns/1ps
module test_two_wire_register_slave
	import twr_pkg::*;
;
	typedef struct packed
	{
		logic        rd;
		logic        rnd;
		logic        sel;
		logic [6:0]  dev;
		logic [15:0] radr;
		logic [7:0]  len;
		logic        nk;
		logic [7:0]  d0;
		logic [7:0]  d1;
	} twr_row_s;

	logic        clk_i = 1'b0;
	logic        resetn_i = 1'b0;
	logic        cmd_valid_i = 1'b0;
	logic        cmd_read_i = 1'b0;
	logic        cmd_random_i = 1'b0;
	logic [6:0]  cmd_dev_addr_i = 7'h00;
	logic [15:0] cmd_reg_addr_i = 16'h0000;
	logic [7:0]  cmd_len_i = 8'h00;
	logic [7:0]  wr_data_i = 8'h00;
	logic        wr_valid_i = 1'b0;
	logic        addr_sel = 1'b0;
	logic        ce = 1'b1;
	logic [7:0]  held = 8'h00;
	logic        cmd_ready_o, wr_ready_o, rd_valid_o, done_o, nack_o, busy_o;
	logic        scl_o, scl_oe_o, sda_o, sda_oe_o, dev_oe;
	logic [7:0]  rd_data_o;
	wire         scl_w = !scl_oe_o;
	wire         sda_w = !(sda_oe_o || dev_oe);
	int          num_errors = 0;
	int          total_checks = 0;
	int          cycles = 0;
	int          widx = 0;
	int          wwait = 0;
	logic [7:0]  wd [2];
	logic [7:0]  rq [$];
	twr_row_s    rows [5];

	twr_master DUT (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce),
		.cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_read_i(cmd_read_i),
		.cmd_random_i(cmd_random_i), .cmd_dev_addr_i(cmd_dev_addr_i),
		.cmd_reg_addr_i(cmd_reg_addr_i), .cmd_len_i(cmd_len_i), .wr_data_i(wr_data_i),
		.wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o), .rd_data_o(rd_data_o),
		.rd_valid_o(rd_valid_o), .done_o(done_o), .nack_o(nack_o), .busy_o(busy_o),
		.scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o));

	twr_slave_model u_dev (.scl_i(scl_w), .sda_i(sda_w), .addr_sel_i(addr_sel),
		.sda_oe_o(dev_oe));

	initial
		forever #2 clk_i = !clk_i;

	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 98000)
		begin
			num_errors++;
			give_verdict();
		end
	end

	// Write data is offered on the third cycle of ready, two cycles late, to show a stalling source is tolerated.
	always @(negedge clk_i)
	begin
		wwait = wr_ready_o ? wwait + 1 : 0;
		wr_valid_i = wwait >= 3;
		wr_data_i = wd[widx[0]];
		if (rd_valid_o === 1'b1)
			rq.push_back(rd_data_o);
	end

	always @(posedge clk_i)
		if (cmd_valid_i)
			widx <= 0;
		else if (wr_valid_i && wr_ready_o)
			widx <= widx + 1;

	task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic run_row(input twr_row_s r);
		int n;
		n = 0;
		addr_sel = r.sel;
		wd[0] = r.d0;
		wd[1] = r.d1;
		rq.delete();
		cmd_read_i = r.rd;
		cmd_random_i = r.rnd;
		cmd_dev_addr_i = r.dev;
		cmd_reg_addr_i = r.radr;
		cmd_len_i = r.len;
		@(negedge clk_i);
		cmd_valid_i = 1'b1;
		@(negedge clk_i);
		cmd_valid_i = 1'b0;
		while (done_o !== 1'b1 && n < 40000)
		begin
			@(negedge clk_i);
			n++;
		end
		check_val("done", 8'h01, {7'h0, done_o});
		check_val("nack", {7'h0, r.nk}, {7'h0, nack_o});
		if (r.rd)
		begin
			check_val("rd_count", r.len, 8'(rq.size()));
			check_val("rd_first", r.d0, rq[0]);
			if (r.len > 8'h01)
				check_val("rd_second", r.d1, rq[1]);
		end
	endtask

	initial
	begin
		// Columns: read, random, pin select, device, register, length, nack, data.
		rows[0] = {3'b000, 7'h2a, 16'h1234, 8'h02, 1'b0, 8'ha5, 8'h3c};
		rows[1] = {3'b110, 7'h10, 16'h1234, 8'h02, 1'b0, 8'ha5, 8'h3c};
		rows[2] = {3'b100, 7'h10, 16'h0000, 8'h01, 1'b0, 8'h36, 8'h00};
		rows[3] = {3'b001, 7'h18, 16'h0040, 8'h00, 1'b0, 8'h00, 8'h00};
		rows[4] = {3'b001, 7'h10, 16'h0040, 8'h00, 1'b1, 8'h00, 8'h00};
		repeat (16) @(negedge clk_i);
		check_val("ready_reset", 8'h01, {7'h0, cmd_ready_o});
		check_val("lines_reset", 8'h00, {6'h0, scl_oe_o, sda_oe_o});
		resetn_i = 1'b1;
		foreach (rows[i])
			run_row(rows[i]);
		// A reset in mid-transfer must free both lines at once, not at the next edge.
		cmd_read_i = 1'b0;
		cmd_valid_i = 1'b1;
		@(negedge clk_i);
		cmd_valid_i = 1'b0;
		repeat (1000) @(negedge clk_i);
		check_val("busy_mid", 8'h01, {7'h0, busy_o});
		// A clock edge is due within the wait, so a frozen engine must show no change.
		held = {6'h0, scl_oe_o, sda_oe_o};
		ce = 1'b0;
		repeat (400) @(negedge clk_i);
		check_val("freeze", held, {6'h0, scl_oe_o, sda_oe_o});
		resetn_i = 1'b0;
		#1;
		check_val("lines_mid_reset", 8'h00, {6'h0, scl_oe_o, sda_oe_o});
		check_val("ready_mid_reset", 8'h01, {7'h0, cmd_ready_o});
		give_verdict();
	end
endmodule

/* verification/twr_master_chk.sv */
`timescale 1ns/1ps
module twr_master_chk
	import twr_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_ready_o,
	input wire logic done_o,
	input wire logic nack_o,
	input wire logic busy_o,
	input wire logic scl_o,
	input wire logic scl_oe_o,
	input wire logic sda_o,
	input wire logic sda_oe_o
);
	logic [31:0] hi_cnt;
	logic [31:0] lo_cnt;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	// Phase lengths are counted, since a repetition cannot span hundreds of cycles.
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			hi_cnt <= 32'h0;
			lo_cnt <= 32'h0;
		end
		else
		begin
			hi_cnt <= scl_oe_o ? 32'h0 : hi_cnt + 32'h1;
			lo_cnt <= scl_oe_o ? lo_cnt + 32'h1 : 32'h0;
		end
	end

	chk_open_drain: assert property (!scl_o && !sda_o)
		else $error("bus line driven high");
	chk_scl_high: assert property ($rose(scl_oe_o) |-> hi_cnt >= 32'(T_HIGH_CYC - ONE_CYC))
		else $error("clock high phase too short");
	chk_scl_low: assert property ($fell(scl_oe_o) |-> lo_cnt >= 32'(T_LOW_CYC - ONE_CYC))
		else $error("clock low phase too short");
	chk_start_setup: assert property ($rose(sda_oe_o) && !scl_oe_o |->
		hi_cnt >= 32'(T_SU_STA_CYC - ONE_CYC)) else $error("start setup too short");
	chk_start_hold: assert property ($rose(sda_oe_o) && !scl_oe_o |=> !scl_oe_o [*8])
		else $error("clock pulled right after start");
	chk_stop_setup: assert property ($fell(sda_oe_o) && !scl_oe_o |->
		hi_cnt >= 32'(T_SU_STO_CYC - ONE_CYC)) else $error("stop setup too short");
	chk_idle_free: assert property (!busy_o |-> !scl_oe_o && !sda_oe_o)
		else $error("line held while idle");
	chk_done_free: assert property (done_o |-> !scl_oe_o && !sda_oe_o)
		else $error("done before bus released");
	chk_nack_hold: assert property (nack_o && !(cmd_valid_i && cmd_ready_o && ce_i) |=> nack_o)
		else $error("nack flag lost");
endmodule

bind twr_master twr_master_chk u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
	.cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o), .nack_o(nack_o),
	.busy_o(busy_o), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o));

/* verification/twr_slave_model.sv */
`timescale 1ns/1ps
module twr_slave_model
	import twr_pkg::*;
#(
	parameter logic [6:0] PROG_ADDR = 7'h2a
)
(
	input  wire logic scl_i,
	input  wire logic sda_i,
	input  wire logic addr_sel_i,
	output logic      sda_oe_o
);
	logic [7:0]  mem [0:65535];
	logic [7:0]  sh = 8'h00;
	logic [15:0] ptr = 16'h0000;
	logic        act = 1'b0;
	logic        rd = 1'b0;
	int          cnt = 0;
	int          byten = 0;
	logic        skip = 1'b0;

	// There is no clock output: the clock is only ever sampled.
	initial
	begin
		sda_oe_o = 1'b0;
		for (int i = 0; i < 65536; i++)
			mem[i] = 8'(i);
	end

	task automatic take_byte();
		if (byten == 0)
		begin
			act = sh[7:1] == (addr_sel_i ? DEV_ADDR_ALT : DEV_ADDR_DEFAULT) ||
				sh[7:1] == PROG_ADDR;
			rd = sh[0];
		end
		else if (byten == 1)
			ptr[15:8] = sh;
		else if (byten == 2)
			ptr[7:0] = sh;
		else
		begin
			mem[ptr] = sh;
			ptr++;
		end
		sda_oe_o = act;
	endtask

	always @(negedge sda_i)
		if (scl_i === 1'b1)
		begin
			act = 1'b1;
			rd = 1'b0;
			cnt = 0;
			byten = 0;
			skip = 1'b1;
		end

	always @(posedge sda_i)
		if (scl_i === 1'b1)
			act = 1'b0;

	always @(posedge scl_i)
		if (act && cnt < 8 && !rd)
			sh = {sh[6:0], sda_i};
		else if (act && cnt == 8 && rd && byten > 0 && sda_i)
			act = 1'b0;

	// Drive only after the falling clock edge, so data is stable while it is high.
	// The clock fall that closes a start is not the end of a bit.
	always @(negedge scl_i)
		if (skip)
			skip = 1'b0;
		else if (act)
		begin
			if (cnt == 8)
			begin
				cnt = 0;
				byten++;
				sh = mem[ptr];
				if (rd)
					ptr++;
				sda_oe_o = rd && !sh[7];
			end
			else if (cnt == 7)
			begin
				cnt = 8;
				if (rd)
					sda_oe_o = 1'b0;
				else
					take_byte();
			end
			else
			begin
				cnt++;
				sda_oe_o = rd && !sh[7 - cnt];
			end
		end
endmodule
